//--- design/tpfs_params.svh
// constants of the two-port frame switch: offsets, fields, resets, counts
// assumes byte addresses on a 32-bit APB with 12 address bits
`ifndef TPFS_PARAMS_SVH
`define TPFS_PARAMS_SVH

// *****
// register offsets
// *****
`define TPFS_CFG2_OFF 12'h004
`define TPFS_DEFACT_OFF 12'h008
`define TPFS_STATUS_OFF 12'h00C
`define TPFS_PORT1_OFF 12'h010
`define TPFS_PORT2_OFF 12'h014
`define TPFS_MGMT_OFF 12'h018
`define TPFS_MAC_PAGE 4'h1

// *****
// field positions and reset values
// *****
`define TPFS_CFG2_PASS_BIT 0
`define TPFS_CFG2_PROTO_BIT 1
`define TPFS_CFG2_PASS_RESET 1'b1
`define TPFS_CFG2_PROTO_RESET 1'b0
`define TPFS_DEFACT_RESET 4'h1
`define TPFS_PORT_AN_BIT 0
`define TPFS_PORT_ROLE_BIT 1
`define TPFS_PORT_ABL_BIT 2
`define TPFS_PORT_REQ_BIT 3
`define TPFS_AN_RESET 1'b1
`define TPFS_PORT1_ROLE_RESET 1'b1
`define TPFS_PORT2_ROLE_RESET 1'b0
`define TPFS_MGMT_BUSY_BIT 31
`define TPFS_MAC_VALID_BIT 20

// *****
// sizes and timing counts
// *****
`define TPFS_QUEUE_BYTES 4096
`define TPFS_MAC_ENTRIES 16
`define TPFS_DA_LAST 3'h5
`define TPFS_STRAP_CYCLES 3'h4
`define TPFS_HOST_ROOM 8

`endif

//--- design/tpfs_pkg.sv
// types shared by the switch and its queue memory
// assumes the constants header is compiled alongside
package tpfs_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } tpfs_byte_s;

  // mask bit 0 is the first port, bit 1 the second
  typedef struct packed {
    logic [1:0] mask;
    tpfs_byte_s b;
  } tpfs_entry_s;

  typedef enum logic [1:0] {
    IN_DA,
    IN_FLUSH,
    IN_BODY
  } tpfs_ing_e;

endpackage

//--- design/tpfs_queue.sv
// one byte queue of the switch: memory, pointers and fill level
// assumes a single clock; read data appear one cycle after rdEn
`timescale 1ns/1ps
module tpfs_queue #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4096
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic wrEn,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic rdEn,
  output logic [WIDTH-1:0] rdData,
  output logic full,
  output logic empty,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("queue depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] level_q;

  assign level = level_q;
  assign full = (level_q == (AW+1)'(DEPTH));
  assign empty = (level_q == '0);

  always_ff @(posedge sys_clk) begin
    if (wrEn && !full) begin
      mem[wrPtr_q] <= wrData;
    end
    rdData <= mem[rdPtr_q];
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      level_q <= '0;
    end else begin
      if (wrEn && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (rdEn && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      level_q <= level_q + (AW+1)'(wrEn && !full)
        - (AW+1)'(rdEn && !empty);
    end
  end
endmodule

//--- design/tpfs_switch.sv
// forwarding core of the three-way frame switch with port configuration
// assumes link clocks, rx pins and straps are asynchronous; autoneg
// results and management answers come from logic on sys_clk
//
// Function
// - frames travel among host port, first PHY port, second PHY port
// - store-and-forward to host; from host and port-to-port, cut-through or store-and-forward
// - port-to-port is cut-through after reset; clearing enable bit stores
// - sixteen address entries pick the receiving endpoints by destination
// - unknown destination uses software-set default forwarding action
// - seven byte queues of 4 kB each for all traffic directions
// - per PHY port separate high and low priority host queues
// - one host transmit queue shared by both PHY ports
// - each port's high-swing select pin picks dual-level or low-only
// - unconnected select pin reads low and gives dual-level mode
// - advertised level ability resets from sampled select pin
// - dual-level with autoneg takes level from partner capabilities
// - exactly one master per link, chosen by autonegotiation
// - host reaches PHY registers through a management bridge
// - host picks generic or MAC-PHY serial framing, both ends agree
// - without autoneg role bit sets role; port one master, two slave
// - with autoneg, high level only if both able and one requests, else low
`timescale 1ns/1ps
`include "tpfs_params.svh"
module tpfs_switch #(
  parameter int QUEUE_DEPTH = `TPFS_QUEUE_BYTES,
  parameter int MAC_ENTRIES = `TPFS_MAC_ENTRIES
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic hostInValid,
  output logic hostInReady,
  input wire tpfs_pkg::tpfs_byte_s hostIn,
  output logic hostOutValid,
  input wire logic hostOutReady,
  output tpfs_pkg::tpfs_byte_s hostOut,
  output logic hostProtocolSel,
  input wire logic [1:0] phyLinkClk,
  input wire logic [1:0] phyRxValid,
  input wire tpfs_pkg::tpfs_byte_s [1:0] phyRx,
  output logic [1:0] phyTxValid,
  output tpfs_pkg::tpfs_byte_s [1:0] phyTx,
  input wire logic firstPortHighSwingSelect,
  input wire logic secondPortHighSwingSelect,
  input wire logic [1:0] anComplete,
  input wire logic [1:0] anMasterWon,
  input wire logic [1:0] lpHighAbility,
  input wire logic [1:0] lpHighRequest,
  output logic [1:0] anEnable,
  output logic [1:0] advHighAbility,
  output logic [1:0] advHighRequest,
  output logic [1:0] txLevelHigh,
  output logic [1:0] roleMaster,
  output logic mgmtValid,
  output logic mgmtWrite,
  output logic mgmtPort,
  output logic [4:0] mgmtReg,
  output logic [15:0] mgmtWdata,
  input wire logic mgmtDone,
  input wire logic [15:0] mgmtRdata
);
  localparam int LW = $clog2(QUEUE_DEPTH) + 1;
  localparam int EW = $bits(tpfs_pkg::tpfs_entry_s);

  if (MAC_ENTRIES < 1 || MAC_ENTRIES > 16) begin : g_bad
    $error("address table holds one to sixteen entries");
  end

  // *****
  // pin synchronisers and link edges
  // *****
  logic [23:0] asyncIn, s1_q, s2_q, s3_q, stable_q, stableD;
  logic [1:0] rise;
  tpfs_pkg::tpfs_byte_s [1:0] rxS;

  assign asyncIn = {secondPortHighSwingSelect, firstPortHighSwingSelect,
    phyLinkClk, phyRxValid, phyRx};
  // a level counts only when the second and third stage agree
  assign stableD = (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
  assign rise = stableD[21:20] & ~stable_q[21:20];
  assign rxS = stableD[17:0];

  always_ff @(posedge sys_clk) begin
    s1_q <= asyncIn;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (srst) begin
      stable_q <= '0;
    end else begin
      stable_q <= stableD;
    end
  end

  // *****
  // registers
  // *****
  logic passThrough_q, defProto_q;
  logic [3:0] defAct_q;
  logic [31:0] macLo_q [16];
  logic [20:0] macHi_q [16];
  logic [1:0] roleBit_q, strap_q;
  logic [2:0] strapCnt_q;
  logic [6:0] ovf_q, full, empty;
  logic [15:0] mgmtRd_q;
  logic wrFire, rdSel, addrBad;
  logic [31:0] rdMux;

  assign wrFire = psel && penable && pwrite && pready;
  assign rdSel = paddr[11:8] == `TPFS_MAC_PAGE && !paddr[7];

  function automatic logic [31:0] portWord(input int p);
    return {25'h0, roleMaster[p], txLevelHigh[p], strap_q[p],
      advHighRequest[p], advHighAbility[p], roleBit_q[p], anEnable[p]};
  endfunction

  // table lookup, lowest matching entry wins
  function automatic logic [3:0] lookup(input logic [47:0] da);
    logic [3:0] r;
    r = defAct_q;
    for (int k = MAC_ENTRIES - 1; k >= 0; k--) begin
      if (macHi_q[k][`TPFS_MAC_VALID_BIT] &&
          {macHi_q[k][15:0], macLo_q[k]} == da) begin
        r = macHi_q[k][19:16];
      end
    end
    return r;
  endfunction

  always_comb begin
    addrBad = 1'b0;
    rdMux = 32'h0;
    case (paddr)
      `TPFS_CFG2_OFF: rdMux = {30'h0, defProto_q, passThrough_q};
      `TPFS_DEFACT_OFF: rdMux = {28'h0, defAct_q};
      `TPFS_STATUS_OFF: rdMux = {18'h0, ovf_q, ~empty};
      `TPFS_PORT1_OFF: rdMux = portWord(0);
      `TPFS_PORT2_OFF: rdMux = portWord(1);
      `TPFS_MGMT_OFF: rdMux = {mgmtValid, 15'h0, mgmtRd_q};
      default: begin
        if (rdSel && paddr[1:0] == 2'h0) begin
          rdMux = paddr[2] ? {11'h0, macHi_q[paddr[6:3]]}
                           : macLo_q[paddr[6:3]];
        end else begin
          addrBad = 1'b1;
        end
      end
    endcase
  end

  // one wait state so that read data leave a flip-flop
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= rdMux;
      pslverr <= psel && penable && !pready && addrBad;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      passThrough_q <= `TPFS_CFG2_PASS_RESET;
      defProto_q <= `TPFS_CFG2_PROTO_RESET;
      defAct_q <= `TPFS_DEFACT_RESET;
      for (int k = 0; k < 16; k++) begin
        macHi_q[k] <= '0;
        macLo_q[k] <= '0;
      end
    end else if (wrFire) begin
      case (paddr)
        `TPFS_CFG2_OFF: begin
          passThrough_q <= pwdata[`TPFS_CFG2_PASS_BIT];
          defProto_q <= pwdata[`TPFS_CFG2_PROTO_BIT];
        end
        `TPFS_DEFACT_OFF: defAct_q <= pwdata[3:0];
        default: begin
          if (rdSel && paddr[2]) begin
            macHi_q[paddr[6:3]] <= pwdata[20:0];
          end else if (rdSel) begin
            macLo_q[paddr[6:3]] <= pwdata;
          end
        end
      endcase
    end
  end

  // framing choice goes to the serial front end
  assign hostProtocolSel = defProto_q;

  // *****
  // per-port level and role
  // *****
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      strapCnt_q <= 3'h0;
      strap_q <= 2'h0;
      anEnable <= {2{`TPFS_AN_RESET}};
      // port one prefers master, port two slave
      roleBit_q <= {`TPFS_PORT2_ROLE_RESET, `TPFS_PORT1_ROLE_RESET};
      advHighAbility <= 2'h0;
      advHighRequest <= 2'h0;
      txLevelHigh <= 2'h0;
      roleMaster <= 2'h0;
    end else begin
      if (strapCnt_q != `TPFS_STRAP_CYCLES) begin
        // strap caught after release; low means dual-level
        strapCnt_q <= strapCnt_q + 3'h1;
        strap_q <= ~stableD[23:22];
        advHighAbility <= ~stableD[23:22];
      end
      for (int p = 0; p < 2; p++) begin
        if (wrFire && paddr == (p == 0 ? `TPFS_PORT1_OFF
                                       : `TPFS_PORT2_OFF)) begin
          anEnable[p] <= pwdata[`TPFS_PORT_AN_BIT];
          roleBit_q[p] <= pwdata[`TPFS_PORT_ROLE_BIT];
          // advertisement bits only settable in dual-level mode
          advHighAbility[p] <= pwdata[`TPFS_PORT_ABL_BIT] & strap_q[p];
          advHighRequest[p] <= pwdata[`TPFS_PORT_REQ_BIT] & strap_q[p];
        end
        // resolved level: both ends' bits with autoneg, own request bit without
        txLevelHigh[p] <= strap_q[p] && advHighAbility[p] && (anEnable[p]
          ? anComplete[p] && lpHighAbility[p]
            && (advHighRequest[p] || lpHighRequest[p])
          : advHighRequest[p]);
        // negotiated role, else the role bit
        roleMaster[p] <= anEnable[p] ? anMasterWon[p] : roleBit_q[p];
      end
    end
  end

  // *****
  // management bridge
  // *****
  // one outstanding transaction; writes while busy are dropped
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mgmtValid <= 1'b0;
      mgmtWrite <= 1'b0;
      mgmtPort <= 1'b0;
      mgmtReg <= 5'h0;
      mgmtWdata <= 16'h0;
      mgmtRd_q <= 16'h0;
    end else if (mgmtValid) begin
      if (mgmtDone) begin
        mgmtValid <= 1'b0;
        mgmtRd_q <= mgmtRdata;
      end
    end else if (wrFire && paddr == `TPFS_MGMT_OFF) begin
      mgmtValid <= 1'b1;
      mgmtWrite <= pwdata[22];
      mgmtPort <= pwdata[21];
      mgmtReg <= pwdata[20:16];
      mgmtWdata <= pwdata[15:0];
    end
  end

  // *****
  // ingress: address capture and lookup
  // *****
  logic [2:0] inV, wV;
  tpfs_pkg::tpfs_byte_s inB [3];
  tpfs_pkg::tpfs_byte_s wB [3];
  logic [3:0] wAct [3];
  logic [LW-1:0] lvl [7];

  assign inV = {rise[1] & stableD[19], rise[0] & stableD[18],
    hostInValid & hostInReady};
  assign inB[0] = hostIn;
  assign inB[1] = rxS[0];
  assign inB[2] = rxS[1];

  for (genvar i = 0; i < 3; i++) begin : g_in
    tpfs_pkg::tpfs_ing_e st_q, st_d;
    logic [7:0] da_q [6];
    logic [2:0] cnt_q, cnt_d;
    logic end6_q;
    logic [3:0] act_q, lk;

    // never send a frame back to where it came from
    always_comb lk = lookup({da_q[0], da_q[1], da_q[2], da_q[3], da_q[4],
      da_q[5]}) & ~{1'b0, 3'(1 << i)};

    always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      wV[i] = 1'b0;
      wB[i] = inB[i];
      wAct[i] = act_q;
      case (st_q)
        tpfs_pkg::IN_DA: begin
          if (inV[i]) begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == `TPFS_DA_LAST) begin
              st_d = tpfs_pkg::IN_FLUSH;
              cnt_d = 3'h0;
            end else if (inB[i].last) begin
              cnt_d = 3'h0;
            end
          end
        end
        // address known: release the held bytes
        tpfs_pkg::IN_FLUSH: begin
          wV[i] = 1'b1;
          wB[i].data = da_q[cnt_q];
          wB[i].last = end6_q && cnt_q == `TPFS_DA_LAST;
          if (cnt_q == 3'h0) begin
            wAct[i] = lk;
          end
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == `TPFS_DA_LAST) begin
            cnt_d = 3'h0;
            st_d = end6_q ? tpfs_pkg::IN_DA : tpfs_pkg::IN_BODY;
          end
        end
        tpfs_pkg::IN_BODY: begin
          wV[i] = inV[i];
          if (inV[i] && inB[i].last) begin
            st_d = tpfs_pkg::IN_DA;
          end
        end
        default: st_d = tpfs_pkg::IN_DA;
      endcase
    end

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        st_q <= tpfs_pkg::IN_DA;
        cnt_q <= 3'h0;
        end6_q <= 1'b0;
        act_q <= 4'h0;
      end else begin
        st_q <= st_d;
        cnt_q <= cnt_d;
        if (st_q == tpfs_pkg::IN_DA && inV[i]) begin
          da_q[cnt_q] <= inB[i].data;
          end6_q <= inB[i].last;
        end
        if (st_q == tpfs_pkg::IN_FLUSH && cnt_q == 3'h0) begin
          act_q <= lk;
        end
      end
    end
  end

  // host is held off while its address bytes drain or queue runs short
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hostInReady <= 1'b0;
    end else begin
      hostInReady <= g_in[0].st_d != tpfs_pkg::IN_FLUSH &&
        lvl[0] < LW'(QUEUE_DEPTH - `TPFS_HOST_ROOM);
    end
  end

  // *****
  // queues
  // *****
  logic [6:0] wr, rd, pend_q;
  tpfs_pkg::tpfs_entry_s wd [7];
  tpfs_pkg::tpfs_entry_s rq [7];
  logic [LW-1:0] fc_q [7];

  // queue 0 host out, 1-4 to host, 5-6 port to port
  assign wr = {wV[2] & wAct[2][1], wV[1] & wAct[1][2],
    wV[2] & wAct[2][0] & ~wAct[2][3], wV[2] & wAct[2][0] & wAct[2][3],
    wV[1] & wAct[1][0] & ~wAct[1][3], wV[1] & wAct[1][0] & wAct[1][3],
    wV[0] & (wAct[0][1] | wAct[0][2])};
  assign wd[0] = {wAct[0][2:1], wB[0]};
  assign wd[1] = {2'h0, wB[1]};
  assign wd[2] = {2'h0, wB[1]};
  assign wd[3] = {2'h0, wB[2]};
  assign wd[4] = {2'h0, wB[2]};
  assign wd[5] = {2'h0, wB[1]};
  assign wd[6] = {2'h0, wB[2]};

  // host-facing queues always store whole frames
  function automatic logic startOk(input int q);
    if (passThrough_q && (q == 0 || q > 4)) begin
      return !empty[q];
    end
    return fc_q[q] != '0;
  endfunction

  for (genvar q = 0; q < 7; q++) begin : g_q
    tpfs_queue #(.WIDTH(EW), .DEPTH(QUEUE_DEPTH)) u_queue (
      .sys_clk(sys_clk),
      .srst(srst),
      .wrEn(wr[q]),
      .wrData(wd[q]),
      .rdEn(rd[q]),
      .rdData(rq[q]),
      .full(full[q]),
      .empty(empty[q]),
      .level(lvl[q])
    );

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        fc_q[q] <= '0;
        ovf_q[q] <= 1'b0;
      end else begin
        fc_q[q] <= fc_q[q] + LW'(wr[q] && !full[q] && wd[q].b.last)
          - LW'(pend_q[q] && rq[q].b.last);
        // overflow set beats a clear in the same cycle
        ovf_q[q] <= (wr[q] && full[q]) || (ovf_q[q] && !(wrFire &&
          paddr == `TPFS_STATUS_OFF && pwdata[7 + q]));
      end
    end
  end

  // *****
  // egress arbitration and two-entry buffers
  // *****
  logic q0Busy_q, hBusy_q;
  logic [1:0] peerBusy_q;
  logic [2:0] hSel_q, hPick, adv, push, v0_q, v1_q;
  tpfs_pkg::tpfs_byte_s pb [3];
  tpfs_pkg::tpfs_byte_s b0_q [3];
  tpfs_pkg::tpfs_byte_s b1_q [3];

  // high priority queues first
  always_comb hPick = startOk(1) ? 3'h1 : startOk(3) ? 3'h3 :
    startOk(2) ? 3'h2 : startOk(4) ? 3'h4 : 3'h0;

  // a queue drains only while its port buffer has room
  assign rd[0] = q0Busy_q && !v1_q[1] && !v1_q[2] && !pend_q[0]
    && !empty[0];
  for (genvar q = 1; q < 5; q++) begin : g_hrd
    assign rd[q] = hBusy_q && hSel_q == 3'(q) && !v1_q[0]
      && !pend_q[q] && !empty[q];
  end
  assign rd[5] = peerBusy_q[1] && !v1_q[2] && !pend_q[5] && !empty[5];
  assign rd[6] = peerBusy_q[0] && !v1_q[1] && !pend_q[6] && !empty[6];

  assign push[0] = hSel_q != 3'h0 && pend_q[hSel_q];
  assign pb[0] = rq[hSel_q].b;
  assign push[1] = (pend_q[0] && rq[0].mask[0]) || pend_q[6];
  assign pb[1] = pend_q[6] ? rq[6].b : rq[0].b;
  assign push[2] = (pend_q[0] && rq[0].mask[1]) || pend_q[5];
  assign pb[2] = pend_q[5] ? rq[5].b : rq[0].b;
  // phy outputs move only on a link edge
  assign adv = {rise, !v0_q[0] || hostOutReady};

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_q <= 7'h0;
      q0Busy_q <= 1'b0;
      peerBusy_q <= 2'h0;
      hBusy_q <= 1'b0;
      hSel_q <= 3'h0;
    end else begin
      pend_q <= rd;
      // host frames take both phy ports so either may receive
      if (pend_q[0] && rq[0].b.last) begin
        q0Busy_q <= 1'b0;
      end else if (!q0Busy_q && peerBusy_q == 2'h0 && startOk(0)) begin
        q0Busy_q <= 1'b1;
      end
      for (int j = 0; j < 2; j++) begin
        if (pend_q[6 - j] && rq[6 - j].b.last) begin
          peerBusy_q[j] <= 1'b0;
        end else if (!q0Busy_q && !startOk(0) && startOk(6 - j)) begin
          peerBusy_q[j] <= 1'b1;
        end
      end
      if (push[0] && pb[0].last) begin
        hBusy_q <= 1'b0;
      end else if (!hBusy_q && hPick != 3'h0) begin
        hBusy_q <= 1'b1;
        hSel_q <= hPick;
      end
    end
  end

  for (genvar e = 0; e < 3; e++) begin : g_out
    always_ff @(posedge sys_clk) begin
      if (srst) begin
        v0_q[e] <= 1'b0;
        v1_q[e] <= 1'b0;
        b0_q[e] <= '0;
        b1_q[e] <= '0;
      end else if (adv[e]) begin
        v0_q[e] <= v1_q[e] || push[e];
        b0_q[e] <= v1_q[e] ? b1_q[e] : pb[e];
        v1_q[e] <= v1_q[e] && push[e];
        b1_q[e] <= pb[e];
      end else if (push[e]) begin
        v1_q[e] <= 1'b1;
        b1_q[e] <= pb[e];
      end
    end
  end

  assign hostOutValid = v0_q[0];
  assign hostOut = b0_q[0];
  assign phyTxValid = v0_q[2:1];
  assign phyTx = {b0_q[2], b0_q[1]};
endmodule

//--- tb/tpfs_checker.sv
// port-level assertions of the frame switch
// assumes it is bound into tpfs_switch
`timescale 1ns/1ps
`include "tpfs_params.svh"
module tpfs_checker (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic hostProtocolSel,
  input wire logic secondPortHighSwingSelect,
  input wire logic [1:0] anComplete,
  input wire logic [1:0] anMasterWon,
  input wire logic [1:0] lpHighAbility,
  input wire logic [1:0] lpHighRequest,
  input wire logic [1:0] anEnable,
  input wire logic [1:0] advHighAbility,
  input wire logic [1:0] txLevelHigh,
  input wire logic [1:0] roleMaster,
  input wire logic mgmtValid,
  input wire logic [4:0] mgmtReg,
  input wire logic [15:0] mgmtWdata,
  input wire logic mgmtDone
);
  // *****
  // properties
  // *****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic wr;
  logic an0;
  assign wr = psel && penable && pready && pwrite;
  assign an0 = anEnable[0] && anComplete[0];
  a_proto_follow: assert property (
    wr && paddr == `TPFS_CFG2_OFF |=> hostProtocolSel == $past(pwdata[1]))
    else $error("protocol select off");
  a_mgmt_start: assert property (
    wr && paddr == `TPFS_MGMT_OFF && !mgmtValid
    |=> mgmtValid && mgmtReg == $past(pwdata[20:16]))
    else $error("bridge did not start");
  a_mgmt_hold: assert property (
    mgmtValid && !mgmtDone |=> mgmtValid && $stable(mgmtReg)
    && $stable(mgmtWdata)) else $error("bridge request moved");
  a_mgmt_drop: assert property (mgmtValid && mgmtDone |=> !mgmtValid)
    else $error("bridge request stuck");
  // held strap must stay out of sync delay
  a_low_only: assert property (secondPortHighSwingSelect [*8]
    |-> !advHighAbility[1] && !txLevelHigh[1]) else $error("low-only broken");
  a_level_cap: assert property (txLevelHigh[0]
    |-> advHighAbility[0] || $past(advHighAbility[0]))
    else $error("high level without ability");
  a_level_low: assert property ((an0 && !lpHighAbility[0]) [*3]
    |-> !txLevelHigh[0]) else $error("level not low");
  a_level_high: assert property ((an0 && advHighAbility[0]
    && lpHighAbility[0] && lpHighRequest[0]) [*3] |-> txLevelHigh[0])
    else $error("level not high");
  a_role_won: assert property ((an0 && anMasterWon[0]) [*3]
    |-> roleMaster[0]) else $error("role not master");
  a_role_lost: assert property ((an0 && !anMasterWon[0]) [*3]
    |-> !roleMaster[0]) else $error("role not slave");
  cover property (wr && paddr == `TPFS_MGMT_OFF);
  cover property (txLevelHigh[0]);
  cover property (mgmtValid && mgmtDone);
endmodule

bind tpfs_switch tpfs_checker i_tpfs_checker (.sys_clk, .srst, .paddr,
  .psel, .penable, .pwrite, .pwdata, .pready, .hostProtocolSel,
  .secondPortHighSwingSelect, .anComplete, .anMasterWon, .lpHighAbility,
  .lpHighRequest, .anEnable, .advHighAbility, .txLevelHigh, .roleMaster,
  .mgmtValid, .mgmtReg, .mgmtWdata, .mgmtDone);

//--- tb/tpfs_link_partner.sv
// link partner of one PHY port: link clock, rx bytes, tx capture
// assumes the switch samples rx at rising link clock
`timescale 1ns/1ps
module tpfs_link_partner (
  input wire logic listen,
  output logic linkClk,
  output logic rxValid,
  output tpfs_pkg::tpfs_byte_s rx,
  input wire logic txValid,
  input wire tpfs_pkg::tpfs_byte_s tx
);
  logic sending = 1'h0;
  tpfs_pkg::tpfs_byte_s got[$];
  // stands still between frames unless listen is set; offset keeps edges off sys_clk
  initial begin
    linkClk = 1'h0;
    rxValid = 1'h0;
    rx = 9'h000;
    #3;
    forever #32 if (sending || listen) linkClk = ~linkClk;
  end
  always @(posedge linkClk) if (txValid) got.push_back(tx);
  task automatic send(input logic [7:0] f [8]);
    sending = 1'h1;
    foreach (f[k]) begin
      @(negedge linkClk);
      rxValid <= 1'h1;
      rx <= {f[k], k == 7};
    end
    @(negedge linkClk);
    rxValid <= 1'h0;
    // released line must not keep the last byte
    rx <= ~rx;
    sending = 1'h0;
  endtask
endmodule

//--- tb/tb_tpfs_switch.sv
// bench of the frame switch: APB tasks, link partners, bridge responder
// assumes package, header, design and partner compile first
`timescale 1ns/1ps
`include "tpfs_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_tpfs_switch;
  logic sys_clk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, hostOutReady = 1'h0, mgmtDone = 1'h0;
  logic firstPortHighSwingSelect = 1'h0, secondPortHighSwingSelect = 1'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, hostOutValid, hostProtocolSel, mgmtValid;
  logic [1:0] anComplete = 2'h0, anMasterWon = 2'h0;
  logic [1:0] lpHighAbility = 2'h0, lpHighRequest = 2'h0;
  logic [1:0] phyTxValid, anEnable, advHighAbility, txLevelHigh, roleMaster;
  logic [4:0] mgmtReg;
  logic [15:0] mgmtRdata = 16'h0;
  wire [1:0] phyLinkClk, phyRxValid;
  wire tpfs_pkg::tpfs_byte_s [1:0] phyRx;
  tpfs_pkg::tpfs_byte_s [1:0] phyTx;
  tpfs_pkg::tpfs_byte_s hostOut;
  tpfs_pkg::tpfs_byte_s hostGot[$];
  logic [7:0] fr [8];
  int n_errors = 0, checked = 0;

  tpfs_switch #(.QUEUE_DEPTH(64)) i_tpfs_switch (.sys_clk, .srst, .paddr,
    .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
    .hostInValid(1'h0), .hostInReady(), .hostIn(9'h000), .hostOutValid,
    .hostOutReady, .hostOut, .hostProtocolSel, .phyLinkClk, .phyRxValid,
    .phyRx, .phyTxValid, .phyTx, .firstPortHighSwingSelect,
    .secondPortHighSwingSelect, .anComplete, .anMasterWon, .lpHighAbility,
    .lpHighRequest, .anEnable, .advHighAbility, .advHighRequest(),
    .txLevelHigh, .roleMaster, .mgmtValid, .mgmtWrite(), .mgmtPort(),
    .mgmtReg, .mgmtWdata(), .mgmtDone, .mgmtRdata);
  tpfs_link_partner i_tpfs_link_partner_1 (.listen(1'h0),
    .linkClk(phyLinkClk[0]), .rxValid(phyRxValid[0]), .rx(phyRx[0]),
    .txValid(phyTxValid[0]), .tx(phyTx[0]));
  tpfs_link_partner i_tpfs_link_partner_2 (.listen(1'h1),
    .linkClk(phyLinkClk[1]), .rxValid(phyRxValid[1]), .rx(phyRx[1]),
    .txValid(phyTxValid[1]), .tx(phyTx[1]));

  always #4 sys_clk = ~sys_clk;
  // bridge answers one cycle late; host side stalls every other cycle
  always @(posedge sys_clk) begin
    mgmtDone <= mgmtValid && !mgmtDone;
    mgmtRdata <= 16'hA500 | 16'(mgmtReg);
    hostOutReady <= ~hostOutReady;
    if (hostOutValid && hostOutReady) hostGot.push_back(hostOut);
  end

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'h0;
    apb(1'h0, `TPFS_CFG2_OFF, 0);
    `CHK(rd[1:0], 2'h1)
    apb(1'h0, `TPFS_DEFACT_OFF, 0);
    `CHK(rd[3:0], `TPFS_DEFACT_RESET)
    apb(1'h0, `TPFS_PORT1_OFF, 0);
    `CHK({rd[4], rd[2:0]}, 4'hF)
    apb(1'h0, `TPFS_PORT2_OFF, 0);
    `CHK({rd[4], rd[2:0]}, 4'h1)
    apb(1'h0, 12'h0FC, 0);
    `CHK(err, 1'h1)
    apb(1'h1, `TPFS_CFG2_OFF, 32'h2);
    apb(1'h0, `TPFS_CFG2_OFF, 0);
    `CHK(rd[1:0], 2'h2)
    `CHK(hostProtocolSel, 1'h1)
    apb(1'h1, `TPFS_PORT1_OFF, 32'h7);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      anComplete <= 2'h3;
      lpHighAbility <= {2{i[0]}};
      lpHighRequest <= {2{i[1]}};
      anMasterWon <= {2{i[0]}};
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK(txLevelHigh, {1'h0, i[0] & i[1]})
      `CHK(roleMaster, {2{i[0]}})
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, `TPFS_PORT2_OFF, 32'(i * 2));
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK(roleMaster[1], i[0])
    end
    apb(1'h1, `TPFS_MGMT_OFF, 32'h0025_0000);
    do apb(1'h0, `TPFS_MGMT_OFF, 0); while (rd[31] !== 1'h0);
    `CHK(rd[15:0], 16'hA505)
    // table entry 0 sends its address to host, unknown goes to port 2
    apb(1'h1, 12'h100, 32'h11);
    apb(1'h1, 12'h104, 32'h0019_0200);
    apb(1'h1, `TPFS_DEFACT_OFF, 32'h4);
    for (int m = 1; m >= 0; m--) begin
      apb(1'h1, `TPFS_CFG2_OFF, 32'(m));
      for (int j = 0; j < 2; j++) begin
        fr = '{8'h02, 8'h00, 8'h00, 8'h00, 8'h00, j ? 8'h22 : 8'h11,
          8'hC1, 8'hC2};
        hostGot.delete();
        i_tpfs_link_partner_2.got.delete();
        i_tpfs_link_partner_1.send(fr);
        repeat (400) if ((j ? i_tpfs_link_partner_2.got.size()
          : hostGot.size()) < 8) @(posedge sys_clk);
        for (int k = 0; k < 8; k++) begin
          if (j) `CHK(i_tpfs_link_partner_2.got[k].data, fr[k])
          else `CHK(hostGot[k].data, fr[k])
        end
      end
    end
    print_verdict();
  end
endmodule
